// [inc/icadc_pkg.sv]
// icadc_pkg: constants, field layouts and types shared by the input-channel
// configuration and conversion sequencer.
// assumes a single 20 MHz core clock; analog front end is outside the logic.
package icadc_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned SLOT_US         = 748;
  localparam int unsigned DIODE_MEAS_US   = 9600;
  localparam int unsigned DIODE_AVG_N     = 16;
  localparam int unsigned SLOT_CYC        = (SLOT_US * (CLK_HZ / 1_000_000));
  localparam int unsigned DIODE_MEAS_CYC  = (DIODE_MEAS_US * (CLK_HZ / 1_000_000));
  localparam int unsigned DIODE_CONV_CYC  = DIODE_MEAS_CYC / DIODE_AVG_N;
  localparam int unsigned SAR_BIT_CYC     = 32;

  // ----------------------------------------------------------------------
  // converter and mode register
  // ----------------------------------------------------------------------
  localparam int unsigned CODE_W          = 8;
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam logic [7:0]  NOMINAL_CODE    = 8'hC0;
  localparam int unsigned VID_W           = 5;
  localparam int unsigned CFG2_IRQ3_BIT   = 6;
  localparam int unsigned CFG2_IRQ4_BIT   = 7;

  // mode register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       vid_as_irq;    // bit 7
    logic [2:0] irq_en;        // bits 6..4 : ext_int_input_two, ext_int_input_one, ext_int_input_zero
    logic       vcc_5v;        // bit 3
    logic       diode2_sel;    // bit 2
    logic       ain_b_sel;     // bit 1
    logic       ain_a_sel;     // bit 0
  } icadc_mode_t;

  typedef enum logic [3:0] {
    CH_TEMP1, CH_V2P5, CH_TEMP2, CH_CORE_RAIL_TWO, CH_V12,
    CH_V5, CH_CORE_RAIL_ONE, CH_VCC, CH_AIN_A, CH_AIN_B
  } icadc_chan_t;

  typedef struct packed {
    icadc_chan_t       chan;
    logic [CODE_W-1:0] data;
  } icadc_result_t;

  typedef struct packed {
    logic tach_input_a;
    logic general_analog_a;
    logic tach_input_b;
    logic general_analog_b;
    logic second_diode;
    logic rail_pair;
  } icadc_pinfunc_t;

endpackage

// [src/icadc_sar.sv]
// icadc_sar: successive-approximation control for the single shared converter.
// assumes comp_in is already synchronised and settles within BIT_CYC cycles.
`timescale 1ns/1ps
module icadc_sar
  import icadc_pkg::*;
#(
  parameter int unsigned BIT_CYC = SAR_BIT_CYC
) (
  input  wire logic              core_clk_in,    // core clock
  input  wire logic              reset_in,       // sync reset, active high
  input  wire logic              ce_in,          // clock enable
  input  wire logic              start_in,       // one-cycle start pulse
  input  wire logic              comp_in,        // high: input above trial level
  output logic [CODE_W-1:0]      trial_out,      // trial code to the dac
  output logic                   done_out,       // one-cycle result pulse
  output logic [CODE_W-1:0]      code_out        // final code
);

  // ----------------------------------------------------------------------
  // bit-serial search, msb first
  // ----------------------------------------------------------------------
  logic [CODE_W-1:0]  code_reg;
  logic [CODE_W-1:0]  mask_reg;
  logic [15:0]        cnt_reg;
  logic               busy_reg;
  logic               done_reg;
  logic               bit_end;
  logic               last_bit;
  logic [CODE_W-1:0]  kept;

  assign bit_end   = busy_reg && (cnt_reg == 16'(BIT_CYC - 1));
  assign last_bit  = mask_reg[0];
  assign kept      = comp_in ? (code_reg | mask_reg) : code_reg;
  assign trial_out = code_reg | mask_reg;
  assign done_out  = done_reg;
  assign code_out  = code_reg;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      code_reg <= '0;
      mask_reg <= '0;
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (ce_in) begin
      done_reg <= 1'b0;
      if (start_in) begin
        code_reg <= '0;
        mask_reg <= {1'b1, {(CODE_W-1){1'b0}}};
        cnt_reg  <= '0;
        busy_reg <= 1'b1;
      end else if (bit_end) begin
        code_reg <= kept;
        mask_reg <= mask_reg >> 1;
        cnt_reg  <= '0;
        busy_reg <= !last_bit;
        done_reg <= last_bit;
      end else if (busy_reg) begin
        cnt_reg  <= cnt_reg + 16'h0001;
      end
    end
  end

endmodule

// [src/icadc_seq.sv]
// icadc_seq: mode register, pin-function decode and round-robin scheduling
// of every measurement input through one shared 8-bit converter.
// assumes the serial slave delivers mode writes as a strobe with data, and
// an analog mux, dac and comparator sit outside this logic.
//
// Functional notes
// - Mode bits 0 and 1 each pick tachometer (0) or analog input (1) for their pin.
// - Mode bit 2 picks the 2.5 V and second core rail inputs (0) or the second diode (1).
// - Mode bit 3 picks the 3.3 V (0) or 5 V (1) scaling of the internal supply reading.
// - Mode bit 7, when set, turns each voltage-ID pin whose enable bit is set into an interrupt input.
// - With bit 7 set, mode bits 4 to 6 each enable the interrupt use of one of three pins.
// - The other two pins take their interrupt enables from bits 6 and 7 of config 2.
// - The first diode input and the three dedicated analog inputs ignore the mode register.
// - The mode register clears to all zeros at reset.
// - All inputs share one successive-approximation converter giving an 8-bit code.
// - Attenuated supplies read code 192 at nominal voltage, leaving headroom to 255.
// - While running, one ordinary input is converted every 748 us, in sequence.
// - A diode reading averages 16 conversions and takes 9.6 ms before moving on.
// - Every configured input goes through the one converter, never in parallel.
// - Once started the inputs are converted and stored in turn until the start bit clears.
// - Diode readings are stored as 8-bit two's complement values.
`timescale 1ns/1ps
module icadc_seq
  import icadc_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES  = SLOT_CYC,        // 748 us at 20 MHz
  parameter int unsigned DIODE_CYCLES = DIODE_CONV_CYC,  // one of 16 diode conversions
  parameter int unsigned BIT_CYCLES   = SAR_BIT_CYC      // settle time per sar bit
) (
  input  wire logic                 core_clk_in,       // 20 MHz core clock
  input  wire logic                 reset_in,          // sync reset, active high
  input  wire logic                 ce_in,             // clock enable
  input  wire logic                 mode_wr_in,        // mode register write strobe
  input  wire logic [7:0]           mode_wdata_in,     // mode register write data
  input  wire logic [7:0]           cfg2_in,           // second configuration register
  input  wire logic                 start_in,          // start bit of configuration
  input  wire logic                 comp_in,           // comparator from analog side
  input  wire logic [VID_W-1:0]     vid_pins_in,       // voltage-ID / interrupt pins
  output logic [7:0]                mode_out,          // mode register read value
  output icadc_pinfunc_t            pinfunc_out,       // decoded shared-pin functions
  output logic [VID_W-1:0]          irq_mode_out,      // pin acts as interrupt input
  output logic [VID_W-1:0]          vid_out,           // vid levels, zero on irq pins
  output logic [VID_W-1:0]          ext_int_out,       // interrupt levels on irq pins
  output icadc_chan_t               mux_sel_out,       // analog mux selection
  output logic                      vcc_5v_out,        // internal supply scaling
  output logic                      diode_drive_out,   // diode current source on
  output logic [CODE_W-1:0]         dac_out,           // sar trial code
  output logic                      busy_out,          // sequencer running
  output logic                      result_valid_out,  // one-cycle store pulse
  output icadc_result_t             result_out         // stored channel and value
);

  // ----------------------------------------------------------------------
  // pin synchronisers: three flops, new level once second and third agree
  // ----------------------------------------------------------------------
  localparam int unsigned SYNC_W = VID_W + 1;

  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] sync3_reg;
  logic [SYNC_W-1:0] stable_reg;
  logic [SYNC_W-1:0] stable_next;
  logic [SYNC_W-1:0] agree;

  assign raw_in      = {comp_in, vid_pins_in};
  assign agree       = ~(sync2_reg ^ sync3_reg);
  assign stable_next = (sync2_reg & agree) | (stable_reg & ~agree);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sync1_reg  <= '0;
      sync2_reg  <= '0;
      sync3_reg  <= '0;
      stable_reg <= '0;
    end else if (ce_in) begin
      sync1_reg  <= raw_in;
      sync2_reg  <= sync1_reg;
      sync3_reg  <= sync2_reg;
      stable_reg <= stable_next;
    end
  end

  // ----------------------------------------------------------------------
  // mode register and pin-function decode
  // ----------------------------------------------------------------------
  icadc_mode_t       mode_reg;
  icadc_pinfunc_t    pinfunc_next;
  logic [VID_W-1:0]  irq_en_all;
  logic [VID_W-1:0]  irq_mode_next;
  logic [VID_W-1:0]  vid_stable;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mode_reg <= icadc_mode_t'(MODE_RESET);
    end else if (ce_in && mode_wr_in) begin
      mode_reg <= icadc_mode_t'(mode_wdata_in);
    end
  end

  assign pinfunc_next.tach_input_a     = !mode_reg.ain_a_sel;
  assign pinfunc_next.general_analog_a = mode_reg.ain_a_sel;
  assign pinfunc_next.tach_input_b     = !mode_reg.ain_b_sel;
  assign pinfunc_next.general_analog_b = mode_reg.ain_b_sel;
  assign pinfunc_next.second_diode     = mode_reg.diode2_sel;
  assign pinfunc_next.rail_pair        = !mode_reg.diode2_sel;

  // pin order core_volt_id_bit_zero..core_volt_id_bit_four; vid3/core_volt_id_bit_four enables come from config 2
  assign irq_en_all    = {cfg2_in[CFG2_IRQ4_BIT], cfg2_in[CFG2_IRQ3_BIT],
                          mode_reg.irq_en};
  assign irq_mode_next = {VID_W{mode_reg.vid_as_irq}} & irq_en_all;
  assign vid_stable    = stable_reg[VID_W-1:0];

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pinfunc_out  <= '0;
      irq_mode_out <= '0;
      vid_out      <= '0;
      ext_int_out  <= '0;
      mode_out     <= MODE_RESET;
    end else if (ce_in) begin
      pinfunc_out  <= pinfunc_next;
      irq_mode_out <= irq_mode_next;
      vid_out      <= vid_stable & ~irq_mode_next;
      ext_int_out  <= vid_stable & irq_mode_next;
      mode_out     <= mode_reg;
    end
  end

  // ----------------------------------------------------------------------
  // channel order; the live mode register, not the slot snapshot, decides which channels exist
  // ----------------------------------------------------------------------
  function automatic icadc_chan_t next_chan(icadc_chan_t cur, icadc_mode_t m);
    icadc_chan_t c;
    c = CH_TEMP1;
    unique case (cur)
      CH_TEMP1:          c = m.diode2_sel ? CH_TEMP2 : CH_V2P5;
      CH_V2P5:           c = CH_CORE_RAIL_TWO;
      CH_TEMP2, CH_CORE_RAIL_TWO: c = CH_V12;
      CH_V12:            c = CH_V5;
      CH_V5:             c = CH_CORE_RAIL_ONE;
      CH_CORE_RAIL_ONE:          c = CH_VCC;
      // tach pins are counted elsewhere, so their slots are skipped
      CH_VCC:            c = m.ain_a_sel ? CH_AIN_A :
                             (m.ain_b_sel ? CH_AIN_B : CH_TEMP1);
      CH_AIN_A:          c = m.ain_b_sel ? CH_AIN_B : CH_TEMP1;
      CH_AIN_B:          c = CH_TEMP1;
      default:           c = CH_TEMP1;
    endcase
    return c;
  endfunction

  // ----------------------------------------------------------------------
  // sequencer: one slot per channel, diode slots run 16 conversions
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_CONV, S_STORE} icadc_state_t;

  icadc_state_t      state_reg;
  icadc_chan_t       chan_reg;
  icadc_mode_t       slot_mode_reg;
  logic [17:0]       tmr_reg;
  logic [3:0]        avg_cnt_reg;
  logic [11:0]       acc_reg;
  logic [CODE_W-1:0] code_reg;
  logic              sar_start_reg;

  logic              sar_done;
  logic [CODE_W-1:0] sar_code;
  logic [CODE_W-1:0] sar_trial;
  logic              is_diode;
  logic [17:0]       conv_len;
  logic              conv_end;
  logic              last_avg;
  logic [11:0]       acc_sum;
  logic [CODE_W-1:0] diode_avg;
  icadc_chan_t       chan_next;
  icadc_chan_t       first_chan;

  assign is_diode   = (chan_reg == CH_TEMP1) || (chan_reg == CH_TEMP2);
  assign conv_len   = is_diode ? 18'(DIODE_CYCLES) : 18'(SLOT_CYCLES);
  assign conv_end   = (tmr_reg == conv_len - 18'h00001);
  assign last_avg   = (avg_cnt_reg == 4'(DIODE_AVG_N - 1));
  // diode codes are signed; sum of 16 fits 12 bits
  assign acc_sum    = acc_reg + {{4{sar_code[CODE_W-1]}}, sar_code};
  assign diode_avg  = acc_reg[11:4];
  assign chan_next  = next_chan(chan_reg, mode_reg);
  assign first_chan = CH_TEMP1;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_reg     <= S_IDLE;
      chan_reg      <= CH_TEMP1;
      slot_mode_reg <= icadc_mode_t'(MODE_RESET);
      tmr_reg       <= '0;
      avg_cnt_reg   <= '0;
      acc_reg       <= '0;
      code_reg      <= '0;
      sar_start_reg <= 1'b0;
    end else if (ce_in) begin
      sar_start_reg <= 1'b0;
      unique case (state_reg)
        S_IDLE: begin
          if (start_in) begin
            state_reg     <= S_CONV;
            chan_reg      <= first_chan;
            slot_mode_reg <= mode_reg;
            tmr_reg       <= '0;
            avg_cnt_reg   <= '0;
            acc_reg       <= '0;
            sar_start_reg <= 1'b1;
          end
        end
        S_CONV: begin
          tmr_reg <= tmr_reg + 18'h00001;
          if (sar_done) begin
            code_reg <= sar_code;
            if (is_diode) begin
              acc_reg <= acc_sum;
            end
          end
          if (conv_end) begin
            tmr_reg <= '0;
            if (is_diode && !last_avg) begin
              avg_cnt_reg   <= avg_cnt_reg + 4'h1;
              sar_start_reg <= 1'b1;
            end else begin
              state_reg <= S_STORE;
            end
          end
        end
        S_STORE: begin
          avg_cnt_reg <= '0;
          acc_reg     <= '0;
          if (start_in) begin
            state_reg     <= S_CONV;
            chan_reg      <= chan_next;
            slot_mode_reg <= mode_reg;
            sar_start_reg <= 1'b1;
          end else begin
            state_reg <= S_IDLE;
            chan_reg  <= CH_TEMP1;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // shared converter and result store
  // ----------------------------------------------------------------------
  icadc_sar #(
    .BIT_CYC     (BIT_CYCLES)
  ) u_sar (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .ce_in       (ce_in),
    .start_in    (sar_start_reg),
    .comp_in     (stable_reg[VID_W]),
    .trial_out   (sar_trial),
    .done_out    (sar_done),
    .code_out    (sar_code)
  );

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mux_sel_out      <= CH_TEMP1;
      vcc_5v_out       <= 1'b0;
      diode_drive_out  <= 1'b0;
      dac_out          <= '0;
      busy_out         <= 1'b0;
      result_valid_out <= 1'b0;
      result_out       <= '0;
    end else if (ce_in) begin
      mux_sel_out      <= chan_reg;
      // attenuators are sized so that a nominal rail lands on NOMINAL_CODE
      vcc_5v_out       <= slot_mode_reg.vcc_5v;
      diode_drive_out  <= (state_reg == S_CONV) && is_diode;
      dac_out          <= sar_trial;
      busy_out         <= (state_reg != S_IDLE);
      result_valid_out <= (state_reg == S_STORE);
      if (state_reg == S_STORE) begin
        result_out.chan <= chan_reg;
        result_out.data <= is_diode ? diode_avg : code_reg;
      end
    end
  end

endmodule

// [dv/icadc_seq_sva.sv]
// icadc_seq_sva: port-level decode and timing checks for icadc_seq.
// assumes ce_in stays high whenever the sequencer runs.
`timescale 1ns/1ps
module icadc_seq_sva
  import icadc_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES  = SLOT_CYC,
  parameter int unsigned DIODE_CYCLES = DIODE_CONV_CYC,
  parameter int unsigned BIT_CYCLES   = SAR_BIT_CYC
) (
  input wire logic             core_clk_in,      // clock
  input wire logic             reset_in,         // sync reset
  input wire logic             ce_in,            // clock enable
  input wire logic             mode_wr_in,       // mode strobe
  input wire logic [7:0]       mode_wdata_in,    // mode data
  input wire logic [7:0]       cfg2_in,          // config 2
  input wire logic             start_in,         // start bit
  input wire logic [7:0]       mode_out,         // mode readback
  input wire icadc_pinfunc_t   pinfunc_out,      // pin functions
  input wire logic [VID_W-1:0] irq_mode_out,     // irq pin select
  input wire logic [VID_W-1:0] vid_out,          // vid levels
  input wire logic [VID_W-1:0] ext_int_out,      // irq levels
  input wire icadc_chan_t      mux_sel_out,      // channel
  input wire logic             vcc_5v_out,       // supply scale
  input wire logic             diode_drive_out,  // diode source
  input wire logic             busy_out,         // running
  input wire logic             result_valid_out, // store pulse
  input wire icadc_result_t    result_out        // stored result
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  // ----------
  // slot gap counter
  // ----------
  // only counts gaps between two stores of one unbroken run; wide enough
  // for a full-length diode slot at the default cycle counts
  logic [17:0] gap_reg;
  logic        run_reg;
  wire logic   diode_res = (result_out.chan == CH_TEMP1) || (result_out.chan == CH_TEMP2);
  always_ff @(posedge core_clk_in) begin
    if (reset_in || !busy_out) begin
      gap_reg <= 18'h00000;
      run_reg <= 1'h0;
    end else if (result_valid_out) begin
      gap_reg <= 18'h00000;
      run_reg <= 1'h1;
    end else if (ce_in) begin
      gap_reg <= gap_reg + 18'h00001;
    end
  end

  // ----------
  // assertions
  // ----------
  AST_MODE_RESET: assert property ($fell(reset_in) |-> mode_out == MODE_RESET)
    else $error("mode register not clear after reset");
  AST_MODE_WRITE: assert property ((ce_in && mode_wr_in) ##1 ce_in |=>
    mode_out == $past(mode_wdata_in, 2)) else $error("mode write not seen");
  AST_PIN_DECODE: assert property (!$past(reset_in) |-> pinfunc_out ==
    {~mode_out[0], mode_out[0], ~mode_out[1], mode_out[1], mode_out[2], ~mode_out[2]})
    else $error("pin function decode wrong");
  AST_IRQ_ENABLE: assert property ($stable(cfg2_in) && cfg2_in == $past(cfg2_in, 2) |->
    irq_mode_out == ({5{mode_out[7]}} & {cfg2_in[7:6], mode_out[6:4]}))
    else $error("interrupt pin select wrong");
  AST_VID_SPLIT: assert property ($stable(irq_mode_out) |->
    ((vid_out & irq_mode_out) == 5'h00) && ((ext_int_out & ~irq_mode_out) == 5'h00))
    else $error("vid and interrupt levels overlap");
  AST_DIODE_DRIVE: assert property (diode_drive_out && $stable(mux_sel_out) |->
    mux_sel_out inside {CH_TEMP1, CH_TEMP2}) else $error("diode source on wrong channel");
  AST_SLOT_PITCH: assert property (result_valid_out && run_reg && !diode_res |->
    gap_reg == 18'(SLOT_CYCLES)) else $error("ordinary slot pitch wrong");
  AST_DIODE_PITCH: assert property (result_valid_out && run_reg && diode_res |->
    gap_reg == 18'(16 * DIODE_CYCLES)) else $error("diode slot pitch wrong");
  AST_START_BUSY: assert property (ce_in && start_in && !busy_out |-> ##[1:2] busy_out)
    else $error("start not taken");
  AST_VALID_PULSE: assert property (result_valid_out |=> !result_valid_out)
    else $error("store pulse too long");
  AST_RESULT_HOLD: assert property (!result_valid_out |-> $stable(result_out))
    else $error("result changed without store");
  AST_VCC_SNAP: assert property ($stable(mux_sel_out) && $past(busy_out) |->
    $stable(vcc_5v_out)) else $error("supply scale changed inside slot");
endmodule

bind icadc_seq icadc_seq_sva #(
  .SLOT_CYCLES(SLOT_CYCLES), .DIODE_CYCLES(DIODE_CYCLES), .BIT_CYCLES(BIT_CYCLES)
) u_sva (
  .core_clk_in, .reset_in, .ce_in, .mode_wr_in, .mode_wdata_in, .cfg2_in, .start_in,
  .mode_out, .pinfunc_out, .irq_mode_out, .vid_out, .ext_int_out, .mux_sel_out,
  .vcc_5v_out, .diode_drive_out, .busy_out, .result_valid_out, .result_out
);

// [dv/icadc_seq_tb_top.sv]
// icadc_seq_tb_top: directed bench for the mode register and sequencer.
// assumes an ideal comparator: each input sits half a code above tgt.
`timescale 1ns/1ps
module icadc_seq_tb_top
  import icadc_pkg::*;
();
  logic             clk, rst, ce, wr, start, comp, v5_seen, v5_o, dd_o, busy_o, rv_o;
  logic             alt = 1'h0;
  logic [7:0]       wdata, cfg2, mode_o, dac_o, dac_q, tgt;
  logic [VID_W-1:0] pins, irq_o, vid_o, ext_o;
  icadc_pinfunc_t   pf_o;
  icadc_chan_t      mux_o;
  icadc_result_t    res_o;
  int               miscompares, num_checks;
  logic [7:0]       mt [5] = '{8'h81, 8'hFF, 8'h7E, 8'hA5, 8'h5A};
  logic [7:0]       ct [5] = '{8'h40, 8'h80, 8'hC0, 8'h00, 8'hFF};

  icadc_seq #(.SLOT_CYCLES(80), .DIODE_CYCLES(80), .BIT_CYCLES(8)) dut (
    .core_clk_in(clk), .reset_in(rst), .ce_in(ce), .mode_wr_in(wr),
    .mode_wdata_in(wdata), .cfg2_in(cfg2), .start_in(start), .comp_in(comp),
    .vid_pins_in(pins), .mode_out(mode_o), .pinfunc_out(pf_o), .irq_mode_out(irq_o),
    .vid_out(vid_o), .ext_int_out(ext_o), .mux_sel_out(mux_o), .vcc_5v_out(v5_o),
    .diode_drive_out(dd_o), .dac_out(dac_o), .busy_out(busy_o),
    .result_valid_out(rv_o), .result_out(res_o)
  );

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // ----------
  // analog side
  // ----------
  // diode codes alternate +16 and -16: a signed average is 0, unsigned 0x80
  always_comb begin
    case (mux_o)
      CH_TEMP1, CH_TEMP2: tgt = alt ? 8'hF0 : 8'h10;
      CH_AIN_A:           tgt = 8'hFF;
      CH_AIN_B:           tgt = 8'h00;
      default:            tgt = NOMINAL_CODE;
    endcase
  end
  always @(posedge clk) begin
    dac_q <= dac_o;
    comp  <= (dac_o <= tgt);
    if (dac_o == 8'h80 && dac_q != 8'h80) begin
      alt <= ~alt;
    end
  end

  // ----------
  // tasks
  // ----------
  function automatic logic [7:0] exp_code(input icadc_chan_t c);
    case (c)
      CH_TEMP1, CH_TEMP2: return 8'h00;
      CH_AIN_A:           return 8'hFF;
      CH_AIN_B:           return 8'h00;
      default:            return NOMINAL_CODE;
    endcase
  endfunction

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic write_mode(input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'h1;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'h0;
  endtask

  task automatic check_mode(input logic [7:0] m, input logic [7:0] c);
    logic [4:0] irq;
    write_mode(m);
    cfg2 <= c;
    pins <= ~m[4:0] ^ c[4:0];
    repeat (8) @(negedge clk);
    irq = {5{m[7]}} & {c[7:6], m[6:4]};
    check(mode_o, m);
    check(pf_o, {~m[0], m[0], ~m[1], m[1], m[2], ~m[2]});
    check(irq_o, irq);
    check({vid_o, ext_o}, {pins & ~irq, pins & irq});
  endtask

  // waits for one store pulse, noting the supply scale seen in a supply slot
  task automatic next_result(output icadc_result_t r);
    int n;
    n = 0;
    while (rv_o !== 1'h1) begin
      @(negedge clk);
      n++;
      if (mux_o == CH_VCC && busy_o === 1'h1) begin
        v5_seen = v5_o;
      end
      if (n > 4000) begin
        miscompares++;
        finish_test();
      end
    end
    r = res_o;
    @(negedge clk);
  endtask

  task automatic expect_chans(input icadc_chan_t q[$]);
    icadc_result_t r;
    foreach (q[i]) begin
      next_result(r);
      check(r, {q[i], exp_code(q[i])});
    end
  endtask

  // ----------
  // main sequence
  // ----------
  initial begin
    // v5_seen starts opposite to the first expected scale, so a missed
    // supply slot cannot pass
    {rst, ce, wr, start, v5_seen} = 5'h19;
    {wdata, cfg2} = 16'h0000;
    pins = 5'h00;
    miscompares = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(negedge clk);
    check(mode_o, MODE_RESET);
    check(pf_o, 6'h29);
    for (int i = 0; i < 5; i++) begin
      check_mode(mt[i], ct[i]);
    end
    @(posedge clk);
    ce <= 1'h0;
    write_mode(8'h33);
    @(posedge clk);
    ce <= 1'h1;
    repeat (3) @(negedge clk);
    check(mode_o, 8'h5A);
    check_mode(8'h00, 8'h00);
    @(posedge clk);
    start <= 1'h1;
    expect_chans('{CH_TEMP1, CH_V2P5, CH_CORE_RAIL_TWO, CH_V12, CH_V5, CH_CORE_RAIL_ONE, CH_VCC});
    check(v5_seen, 1'h0);
    check_mode(8'h0F, 8'h00);
    expect_chans('{CH_TEMP1, CH_TEMP2, CH_V12, CH_V5, CH_CORE_RAIL_ONE,
                   CH_VCC, CH_AIN_A, CH_AIN_B, CH_TEMP1});
    check(v5_seen, 1'h1);
    @(posedge clk);
    start <= 1'h0;
    expect_chans('{CH_TEMP2});
    repeat (3) @(negedge clk);
    check(busy_o, 1'h0);
    @(posedge clk);
    start <= 1'h1;
    repeat (100) @(posedge clk);
    rst <= 1'h1;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    check(mode_o, MODE_RESET);
    expect_chans('{CH_TEMP1, CH_V2P5});
    finish_test();
  end
endmodule
